// File: include/fsgr_pkg.sv
// Constants for the fault status and general-purpose IO register block.
// Assumes an 8-bit register port on sys_clk and a serial link sampled on sys_clk.
package fsgr_pkg;

  // Register offsets
  localparam logic [7:0] FSGR_ADDR_FAULTN = 8'h13;
  localparam logic [7:0] FSGR_ADDR_GPIO = 8'h14;
  localparam logic [7:0] FSGR_ADDR_INT_STAT = 8'h15;
  localparam logic [7:0] FSGR_ADDR_INT_MASK = 8'h16;
  localparam logic [7:0] FSGR_ADDR_CLK_CTRL = 8'h17;

  // Reset values
  localparam logic [7:0] FSGR_RST_FAULTN = 8'h00;
  localparam logic [3:0] FSGR_RST_IO_DATA = 4'h0;
  localparam logic [3:0] FSGR_RST_IO_DIR = 4'hf;
  localparam logic [3:0] FSGR_RST_INT = 4'h0;
  localparam logic [2:0] FSGR_RST_RATE = 3'h6;

  // Field positions of the IO register
  localparam int FSGR_IO_DIR_LSB = 0;
  localparam int FSGR_IO_DATA_LSB = 4;

  // Field positions of the clock control register
  localparam int FSGR_CLK_RATE_LSB = 0;
  localparam int FSGR_CLK_OUT_EN_BIT = 3;

  // Interrupt status bits
  localparam int FSGR_IRQ_FAULT = 0;
  localparam int FSGR_IRQ_IO_CHANGE = 1;
  localparam int FSGR_IRQ_DATA_READY = 2;
  localparam int FSGR_IRQ_START = 3;

  // Highest data rate code; larger codes are clamped to it
  localparam logic [2:0] FSGR_RATE_MAX = 3'h6;

  // Start-to-ready latency at the fastest rate, in sys_clk cycles
  localparam logic [15:0] FSGR_DATA_READY_N_BASE_CYC = 16'h0040;

  // Conversion sequencer states
  typedef enum logic [2:0] {
    FSGR_CONV_IDLE = 3'b001,
    FSGR_CONV_WAIT = 3'b010,
    FSGR_CONV_READY = 3'b100
  } fsgr_conv_t;

endpackage

// File: verification/fsgr_spi_host.sv
// Serial host model: selects the converter and clocks one byte out.
// Assumes sclk idles low and data is taken on its rising edge.
`timescale 1ns/1ps
module fsgr_spi_host (
  // Serial lines
  output logic cs_n,
  output logic sclk,
  input wire logic sdo
);
  // Idle: deselected, clock standing still
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  task automatic xfer(output logic [7:0] b);
    cs_n = 1'b0;
    #62.5;
    repeat (8) begin
      sclk = 1'b1;
      b = {b[6:0], sdo};
      #62.5;
      sclk = 1'b0;
      #62.5;
    end
    cs_n = 1'b1;
  endtask
endmodule

// File: verification/fsgr_sva.sv
// Checker of the fault and IO register block.
// Assumes it is bound to fsgr_regs and sees its ports only.
`timescale 1ns/1ps
module fsgr_sva
  import fsgr_pkg::*;
#(parameter int NUM_CH = 8, parameter int NUM_IO = 4) (
  // Clock and register port
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic [NUM_CH-1:0] ch_neg_over_threshold,
  input wire logic [NUM_IO-1:0] io_pin_in,
  input wire logic [NUM_IO-1:0] io_pin_out,
  input wire logic [NUM_IO-1:0] io_pin_oe_n,
  input wire logic cs_n,
  input wire logic sdo_oe_n,
  input wire logic data_ready_n,
  input wire logic clock_source_select_pin,
  input wire logic clk_out,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Strobes aimed at one register
  wire logic gw = reg_wr && reg_addr == FSGR_ADDR_GPIO;
  wire logic gr = reg_rd && reg_addr == FSGR_ADDR_GPIO;
  wire logic fr = reg_rd && reg_addr == FSGR_ADDR_FAULTN;
  // Synced inputs are held five edges so the two-flop lag has passed
  a_dir_write: assert property (gw |=> io_pin_oe_n == $past(reg_wdata[3:0]))
    else $error("direction not taken");
  a_dir_read: assert property (gr |=> reg_rdata[3:0] == $past(io_pin_oe_n))
    else $error("direction not read");
  a_out_write: assert property (gw |=>
    io_pin_out == (($past(io_pin_oe_n) & $past(io_pin_out)) | (~$past(io_pin_oe_n) & $past(reg_wdata[7:4]))))
    else $error("output latch wrong");
  a_pins_read: assert property ($stable(io_pin_in) [*5] ##0 gr |=>
    reg_rdata[7:4] == $past(io_pin_in)) else $error("pin levels not read");
  a_fault_read: assert property ($stable(ch_neg_over_threshold) [*5] ##0 fr |=>
    reg_rdata == $past(ch_neg_over_threshold)) else $error("fault flags wrong");
  a_sdo_release: assert property (cs_n [*5] |-> sdo_oe_n) else $error("data line held");
  a_slave_clk: assert property (!clock_source_select_pin [*5] |-> !clk_out)
    else $error("slave drives clock");
  a_irq_off: assert property (reg_wr && reg_addr == FSGR_ADDR_INT_MASK && reg_wdata[3:0] == 4'h0 |=> !irq)
    else $error("irq while all masked");
  // Main scenarios
  cover property (gw);
  cover property ($fell(cs_n));
  cover property ($fell(data_ready_n));
endmodule
bind fsgr_regs fsgr_sva #(.NUM_CH(NUM_CH), .NUM_IO(NUM_IO)) u_sva (.sys_clk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .ch_neg_over_threshold, .io_pin_in, .io_pin_out, .io_pin_oe_n, .cs_n,
  .sdo_oe_n, .data_ready_n, .clock_source_select_pin, .clk_out, .irq);

// File: verification/tb.sv
// Testbench of the fault and IO register block.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
module tb;
  import fsgr_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} fsgr_row_t;
  logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, start = 0, css = 1, c;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, ch = 0, d;
  logic [3:0] io_pin_in, io_pin_out, io_pin_oe_n;
  logic cs_n, sclk, sdo_out, sdo_oe_n, data_ready_n, clk_out, irq;
  wire sdo;
  int n_errors = 0, n_tests = 0, cyc = 0, n0, n1, n2, n3, n4;
  // Reads follow each write so read-only and input pins show
  fsgr_row_t rows [15] = '{'{0, 8'h13, 8'h00}, '{0, 8'h14, 8'h1f}, '{0, 8'h20, 8'h00}, '{1, 8'h13, 8'hff},
    '{0, 8'h13, 8'h00}, '{1, 8'h14, 8'ha3}, '{0, 8'h14, 8'h13}, '{1, 8'h14, 8'ha3}, '{0, 8'h14, 8'h93},
    '{1, 8'h14, 8'h50}, '{0, 8'h14, 8'h40}, '{1, 8'h14, 8'h50}, '{0, 8'h14, 8'h50}, '{0, 8'h16, 8'h00},
    '{0, 8'h17, 8'h06}};
  // Pin wire: a driving output wins, otherwise the outside holds 1 on pin 0
  assign io_pin_in = (~io_pin_oe_n & io_pin_out) | (io_pin_oe_n & 4'h1);
  assign sdo = sdo_oe_n ? 1'bz : sdo_out;
  always #2 sys_clk = ~sys_clk;
  // Short ready count keeps the rate steps quick
  fsgr_regs #(.DATA_READY_N_BASE_CYC(16'h0008)) u_dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ch_neg_over_threshold(ch), .io_pin_in, .io_pin_out, .io_pin_oe_n, .cs_n, .sclk, .sdo_out,
    .sdo_oe_n, .start, .data_ready_n, .clock_source_select_pin(css), .clk_out, .irq);
  fsgr_spi_host u_host (.cs_n, .sclk, .sdo);
  // Bus and compare helpers; each bus task ends on a rising edge
  task w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    w(1);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    w(1);
    reg_rd <= 1'b0;
    @(negedge sys_clk) v = reg_rdata;
    w(1);
  endtask
  // Start to ready cycles at one rate code
  task meas(input logic [2:0] r, output int n);
    wr(FSGR_ADDR_CLK_CTRL, {5'h01, r});
    start <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((n < 8 || data_ready_n !== 1'b0) && n < 2000);
    @(posedge sys_clk) start <= 1'b0;
    w(4);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well above the run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    w(8);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, d);
      if (!rows[i].w) chk("reg", rows[i].d, d);
      w(4);
    end
    $display("test table done");
    ch <= 8'h81;
    w(6);
    rd(FSGR_ADDR_FAULTN, d);
    chk("fault", 8'h81, d);
    ch <= 8'h02;
    w(6);
    rd(FSGR_ADDR_FAULTN, d);
    chk("fault_follow", 8'h02, d);
    wr(FSGR_ADDR_INT_MASK, 8'h01);
    w(1);
    chk("irq_on", 8'h01, {7'h0, irq});
    wr(FSGR_ADDR_INT_STAT, 8'h0f);
    w(1);
    chk("irq_clear", 8'h00, {7'h0, irq});
    ch <= 8'h06;
    w(6);
    chk("irq_event", 8'h01, {7'h0, irq});
    wr(FSGR_ADDR_INT_MASK, 8'h00);
    w(1);
    chk("irq_mask", 8'h00, {7'h0, irq});
    $display("test fault and irq done");
    u_host.xfer(d);
    chk("spi_byte", 8'h06, d);
    w(4);
    chk("sdo_oe_n", 8'h01, {7'h0, sdo_oe_n});
    meas(3'h0, n0);
    meas(3'h1, n1);
    meas(3'h0, n2);
    meas(3'h6, n3);
    meas(3'h7, n4);
    chk("ready_repeat", 8'(n0), 8'(n2));
    chk("ready_step", 8'h08, 8'(n1 - n0));
    chk("ready_slowest", 8'h3f, 8'((n3 - n0) >> 3));
    chk("ready_clamp", 8'h00, {7'h0, n4 != n3});
    // Fault, start and ready events are pending; pins have not moved
    rd(FSGR_ADDR_INT_STAT, d);
    chk("int_stat", 8'h0d, d);
    wr(FSGR_ADDR_INT_STAT, 8'h0d);
    w(1);
    rd(FSGR_ADDR_INT_STAT, d);
    chk("int_clear", 8'h00, d);
    @(negedge sys_clk) c = clk_out;
    @(negedge sys_clk) chk("clk_out", {7'h0, ~c}, {7'h0, clk_out});
    @(posedge sys_clk) css <= 1'b0;
    w(6);
    chk("clk_slave", 8'h00, {7'h0, clk_out});
    $display("test link, ready and clock done");
    reset <= 1'b1;
    w(2);
    reset <= 1'b0;
    w(4);
    rd(FSGR_ADDR_GPIO, d);
    chk("gpio_reset", 8'h1f, d);
    chk("irq_reset", 8'h00, {7'h0, irq});
    chk("data_ready_n_reset", 8'h01, {7'h0, data_ready_n});
    $display("test reset done");
    end_of_test();
  end
endmodule

// File: verilog/fsgr_regs.sv
// Fault status flags, general-purpose IO, conversion alignment and clock sharing.
// Assumes comparator outputs, IO pins, chip select, serial clock, start and the
// clock-source strap all arrive asynchronously; each passes two flip-flops first.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// (RULE_01) Fault bit n reflects channel n+1 comparator
// (RULE_02) Fault register read-only, zero after reset
// (RULE_03) Fault register at 13h, resets 00h
// (RULE_04) Low nibble: direction, 1 input, reset Fh
// (RULE_05) High nibble reads actual pin levels
// (RULE_06) Data writes drive only output pins
// (RULE_07) IO register at 14h, resets 0Fh
// (RULE_08) Serial output released while chip select high
// (RULE_09) Host shares lines, one select at once
// (RULE_10) Start-to-ready delay fixed per data rate
// (RULE_11) Clock master drives its clock out
// (RULE_12) Fault flags follow comparators, no latching
module fsgr_regs
  import fsgr_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int NUM_IO = 4,
  parameter logic [15:0] DATA_READY_N_BASE_CYC = FSGR_DATA_READY_N_BASE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Comparator outputs, bit 7 channel 8 down to bit 0 channel 1
  input wire logic [NUM_CH-1:0] ch_neg_over_threshold,
  // General-purpose IO pins
  input wire logic [NUM_IO-1:0] io_pin_in,
  output logic [NUM_IO-1:0] io_pin_out,
  output logic [NUM_IO-1:0] io_pin_oe_n,
  // Serial link
  input wire logic cs_n,
  input wire logic sclk,
  output logic sdo_out,
  output logic sdo_oe_n,
  // Conversion control
  input wire logic start,
  output logic data_ready_n,
  // Clock sharing
  input wire logic clock_source_select_pin,
  output logic clk_out,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [NUM_CH-1:0] fault_s1;
    logic [NUM_CH-1:0] fault_s2;
    logic [NUM_CH-1:0] fault_q;
    logic [NUM_IO-1:0] io_s1;
    logic [NUM_IO-1:0] io_s2;
    logic [NUM_IO-1:0] io_seen_q;
    logic [NUM_IO-1:0] io_dir_q;
    logic [NUM_IO-1:0] io_out_q;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic start_s1;
    logic start_s2;
    logic start_s3;
    logic csel_s1;
    logic csel_s2;
    logic [2:0] rate_q;
    logic clk_en_q;
    logic clk_out_q;
    logic [3:0] int_stat_q;
    logic [3:0] int_mask_q;
    logic irq_q;
    logic [7:0] rdata_q;
    logic [7:0] shift_q;
    logic sdo_q;
    logic sdo_oe_n_q;
    fsgr_conv_t conv_q;
    logic [15:0] lat_cnt_q;
    logic data_ready_n_n_q;
  } fsgr_state_t;

  fsgr_state_t s_q;
  fsgr_state_t s_d;

  // Decoded accesses and edges
  logic wr_gpio;
  logic wr_stat;
  logic wr_mask;
  logic wr_clk;
  logic sclk_fall;
  logic cs_fall;
  logic start_rise;
  logic [2:0] rate_eff;
  logic [15:0] lat_target;
  logic [3:0] events;
  logic [NUM_CH-1:0] fault_next;

  // Bus decode; unmapped writes are dropped
  assign wr_gpio = reg_wr && (reg_addr == FSGR_ADDR_GPIO);
  assign wr_stat = reg_wr && (reg_addr == FSGR_ADDR_INT_STAT);
  assign wr_mask = reg_wr && (reg_addr == FSGR_ADDR_INT_MASK);
  assign wr_clk = reg_wr && (reg_addr == FSGR_ADDR_CLK_CTRL);

  // Edges are taken from the second and third stages, never the first
  assign sclk_fall = s_q.sclk_s3 && !s_q.sclk_s2;
  assign cs_fall = s_q.cs_s3 && !s_q.cs_s2;
  assign start_rise = !s_q.start_s3 && s_q.start_s2;

  // (RULE_10) latency per rate
  // Slower rates double the wait; unused codes clamp so the delay never drifts
  assign rate_eff = (s_q.rate_q > FSGR_RATE_MAX) ? FSGR_RATE_MAX : s_q.rate_q;
  assign lat_target = DATA_READY_N_BASE_CYC << rate_eff;

  // (RULE_12) flags track comparators
  assign fault_next = s_q.fault_s2;

  always_comb begin
    s_d = s_q;
    events = 4'h0;

    // Two-stage synchronisers for every asynchronous input
    s_d.fault_s1 = ch_neg_over_threshold;
    s_d.fault_s2 = s_q.fault_s1;
    s_d.io_s1 = io_pin_in;
    s_d.io_s2 = s_q.io_s1;
    s_d.cs_s1 = cs_n;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.cs_s3 = s_q.cs_s2;
    s_d.sclk_s1 = sclk;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_s3 = s_q.sclk_s2;
    s_d.start_s1 = start;
    s_d.start_s2 = s_q.start_s1;
    s_d.start_s3 = s_q.start_s2;
    s_d.csel_s1 = clock_source_select_pin;
    s_d.csel_s2 = s_q.csel_s1;

    // (RULE_01) per-channel fault flags
    // Not writable from the bus, so no write path exists here
    s_d.fault_q = fault_next;
    if ((fault_next & ~s_q.fault_q) != '0) begin
      events[FSGR_IRQ_FAULT] = 1'b1;
    end

    // Pin changes on input pins raise an event
    s_d.io_seen_q = s_q.io_s2;
    if (((s_q.io_s2 ^ s_q.io_seen_q) & s_q.io_dir_q) != '0) begin
      events[FSGR_IRQ_IO_CHANGE] = 1'b1;
    end

    // (RULE_04) direction field write
    if (wr_gpio) begin
      s_d.io_dir_q = reg_wdata[FSGR_IO_DIR_LSB +: NUM_IO];
    end

    // (RULE_06) data write masked by direction
    // Input pins keep their old latch value so a later switch to output is predictable
    if (wr_gpio) begin
      for (int i = 0; i < NUM_IO; i++) begin
        if (!s_q.io_dir_q[i]) begin
          s_d.io_out_q[i] = reg_wdata[FSGR_IO_DATA_LSB + i];
        end
      end
    end

    // Own control registers
    if (wr_mask) begin
      s_d.int_mask_q = reg_wdata[3:0];
    end
    if (wr_clk) begin
      s_d.rate_q = reg_wdata[FSGR_CLK_RATE_LSB +: 3];
      s_d.clk_en_q = reg_wdata[FSGR_CLK_OUT_EN_BIT];
    end

    // Read data stands only in the cycle after the read strobe
    s_d.rdata_q = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        // (RULE_03) fault register read
        FSGR_ADDR_FAULTN: s_d.rdata_q = 8'(s_q.fault_q);
        // (RULE_05) pins read back
        FSGR_ADDR_GPIO: s_d.rdata_q = {s_q.io_s2, s_q.io_dir_q};
        FSGR_ADDR_INT_STAT: s_d.rdata_q = {4'h0, s_q.int_stat_q};
        FSGR_ADDR_INT_MASK: s_d.rdata_q = {4'h0, s_q.int_mask_q};
        FSGR_ADDR_CLK_CTRL: s_d.rdata_q = {4'h0, s_q.clk_en_q, s_q.rate_q};
        default: s_d.rdata_q = 8'h00;
      endcase
    end

    // (RULE_10) fixed start-to-ready sequence
    // A new start edge always restarts the count, so aligned starts stay aligned
    unique case (s_q.conv_q)
      FSGR_CONV_IDLE: begin
        if (start_rise) begin
          s_d.conv_q = FSGR_CONV_WAIT;
          s_d.lat_cnt_q = 16'h0001;
        end
      end
      FSGR_CONV_WAIT: begin
        if (start_rise) begin
          s_d.lat_cnt_q = 16'h0001;
        end else if (s_q.lat_cnt_q >= lat_target) begin
          s_d.conv_q = FSGR_CONV_READY;
          s_d.data_ready_n_n_q = 1'b0;
          events[FSGR_IRQ_DATA_READY] = 1'b1;
        end else begin
          s_d.lat_cnt_q = s_q.lat_cnt_q + 16'h0001;
        end
      end
      FSGR_CONV_READY: begin
        if (start_rise) begin
          s_d.conv_q = FSGR_CONV_WAIT;
          s_d.lat_cnt_q = 16'h0001;
          s_d.data_ready_n_n_q = 1'b1;
        end else if (cs_fall) begin
          s_d.data_ready_n_n_q = 1'b1;
          s_d.conv_q = FSGR_CONV_IDLE;
        end
      end
      default: begin
        s_d.conv_q = FSGR_CONV_IDLE;
        s_d.data_ready_n_n_q = 1'b1;
      end
    endcase
    if (start_rise) begin
      events[FSGR_IRQ_START] = 1'b1;
    end

    // Serial output shifts the fault flags out, msb first, on falling serial clock
    // Channels above the flag count shift out as zeros, bar the first bit, which carries the top flag
    if (cs_fall) begin
      s_d.shift_q = 8'(s_q.fault_q);
      s_d.sdo_q = s_q.fault_q[NUM_CH-1];
    end else if (!s_q.cs_s2 && sclk_fall) begin
      s_d.shift_q = {s_q.shift_q[6:0], 1'b0};
      s_d.sdo_q = s_q.shift_q[6];
    end

    // (RULE_08) release output when deselected
    // The synchroniser lag keeps the line driven a few cycles after deselect
    // (RULE_09) relies on host selecting one device
    s_d.sdo_oe_n_q = s_q.cs_s2;

    // (RULE_11) clock master output
    // Half-rate toggle; held low when not master so no runt pulses leave the chip
    if (s_q.csel_s2 && s_q.clk_en_q) begin
      s_d.clk_out_q = !s_q.clk_out_q;
    end else begin
      s_d.clk_out_q = 1'b0;
    end

    // Sticky status: set wins over a same-cycle write-one clear
    if (wr_stat) begin
      s_d.int_stat_q = s_q.int_stat_q & ~reg_wdata[3:0];
    end
    s_d.int_stat_q = s_d.int_stat_q | events;
    s_d.irq_q = (s_d.int_stat_q & s_d.int_mask_q) != 4'h0;
  end

  // (RULE_02) zero flags at reset
  // (RULE_07) IO register reset value
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.fault_q <= FSGR_RST_FAULTN;
      s_q.io_dir_q <= FSGR_RST_IO_DIR;
      s_q.io_out_q <= FSGR_RST_IO_DATA;
      s_q.int_stat_q <= FSGR_RST_INT;
      s_q.int_mask_q <= FSGR_RST_INT;
      s_q.rate_q <= FSGR_RST_RATE;
      // Select stages reset high so no false select edge follows reset
      s_q.cs_s1 <= 1'b1;
      s_q.cs_s2 <= 1'b1;
      s_q.cs_s3 <= 1'b1;
      s_q.sdo_oe_n_q <= 1'b1;
      s_q.data_ready_n_n_q <= 1'b1;
      s_q.conv_q <= FSGR_CONV_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  assign reg_rdata = s_q.rdata_q;
  assign io_pin_out = s_q.io_out_q;
  assign io_pin_oe_n = s_q.io_dir_q;
  assign sdo_out = s_q.sdo_q;
  assign sdo_oe_n = s_q.sdo_oe_n_q;
  assign data_ready_n = s_q.data_ready_n_n_q;
  assign clk_out = s_q.clk_out_q;
  assign irq = s_q.irq_q;

endmodule
